// File: src/scs_pkg.sv
package scs_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [1:0] SCS_SEL_OFFS   = 2'h0; // system_clock_select
  localparam logic [1:0] SCS_STAT_OFFS  = 2'h1; // Applied divider and flags
  localparam logic [1:0] SCS_MCYC_OFFS  = 2'h2; // Machine cycle count, low nibble

  // ----------------------------------------------------------------
  // Field positions and reset value
  // ----------------------------------------------------------------
  localparam int         SCS_SUB_BIT    = 0;     // sub_clock_select_bit
  localparam int         SCS_STOP_BIT   = 1;     // main_clock_stop_bit
  localparam int         SCS_DIV_LO     = 2;     // divider_low_bit
  localparam int         SCS_DIV_HI     = 3;     // divider_high_bit
  localparam logic [3:0] SCS_SEL_RST    = 4'hC;  // Divide by eight, main clock
  localparam logic [1:0] SCS_INSTR_DIV  = 2'h3;  // System ticks per instruction tick

  // Select register layout
  typedef struct packed {
    logic [1:0] div;      // Divider field
    logic       main_stop; // main_clock_stop_bit
    logic       sub_sel;   // sub_clock_select_bit
  } scs_cfg_t;

  // Clock ticks leaving the block
  typedef struct packed {
    logic sys_tick;    // One pulse per system clock cycle
    logic instr_tick;  // One pulse per instruction clock cycle
  } scs_ticks_t;

  // Divider field to terminal count of source edges
  function automatic logic [2:0] scs_div_last(input logic [1:0] div);
    scs_div_last = 3'((4'h1 << div) - 4'h1);
  endfunction : scs_div_last

endpackage : scs_pkg

// File: src/scs_edge_sync.sv
`timescale 1ns/100ps
// ------------------------------------------------------------------
// Oscillator pin synchroniser with rising-edge pulse
// ------------------------------------------------------------------
module scs_edge_sync (
  input  wire logic clk_sys_in,  // System clock
  input  wire logic rst_n_in,    // Synchronous reset, active low
  input  wire logic osc_in,      // Asynchronous oscillator pin
  output logic      rise_out     // One-cycle pulse per rising edge
);
  logic meta_r;   // First stage, read only by sync_r
  logic sync_r;   // Second stage
  logic prev_r;   // Delayed copy for edge detect

  // Two-flop chain; the oscillator must run below half clk_sys_in
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end
    else
    begin
      meta_r <= osc_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign rise_out = sync_r & ~prev_r;

endmodule : scs_edge_sync

// File: src/scs_instr_div.sv
`timescale 1ns/100ps
// ------------------------------------------------------------------
// Instruction clock: system tick divided by three
// ------------------------------------------------------------------
module scs_instr_div
(
  input  wire logic clk_sys_in,   // System clock
  input  wire logic rst_n_in,     // Synchronous reset, active low
  input  wire logic sys_tick_in,  // System clock tick
  output logic      instr_tick_out // Instruction clock tick
);
  import scs_pkg::*;

  logic [1:0] phase_r; // Position within the instruction cycle

  // Wrap after three system ticks
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
      phase_r <= 2'h0;
    else if (sys_tick_in)
      phase_r <= (phase_r == SCS_INSTR_DIV - 2'h1) ? 2'h0 : phase_r + 2'h1;
  end

  // Registered pulse so consumers see a clean one-cycle strobe
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
      instr_tick_out <= 1'b0;
    else
      instr_tick_out <= sys_tick_in && (phase_r == SCS_INSTR_DIV - 2'h1);
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  a_instr_third : assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    instr_tick_out |-> $past(sys_tick_in) && $past(phase_r) == 2'h2)
    else $error("instruction tick not on third system tick");

endmodule : scs_instr_div

// File: src/scs_clock_selector.sv
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/100ps
// ------------------------------------------------------------------
// System clock selector
// Oscillator pins are sampled on clk_sys_in; the selected source is
// divided into a system tick, then into instruction ticks.
// ------------------------------------------------------------------
module scs_clock_selector
(
  input  wire logic             clk_sys_in,             // 100 MHz clock
  input  wire logic             rst_n_in,               // Synchronous reset, active low
  input  wire logic             main_xin_in,            // Ceramic, RC or external input
  input  wire logic             ring_osc_in,            // On-chip oscillator
  input  wire logic             sub_xcin_in,            // Sub-clock oscillator
  input  wire logic             ceramic_select_instr_in, // Ceramic select executed
  input  wire logic             rc_select_instr_in,     // RC select executed
  input  wire logic [1:0]       addr_in,                // Register address
  input  wire logic [3:0]       wdata_in,               // Write data
  input  wire logic             wr_in,                  // Write strobe
  input  wire logic             rd_in,                  // Read strobe
  output logic      [3:0]       rdata_out,              // Read data, cycle after rd_in
  output scs_pkg::scs_ticks_t   ticks_out,              // System and instruction ticks
  output logic                  machine_cycle_out,      // One pulse per machine cycle
  output logic                  main_osc_enable_out,    // Main oscillator running
  output logic                  main_is_xin_out         // Main source is XIN pin
);
  import scs_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  scs_cfg_t   sel_r;        // Software copy of system_clock_select
  scs_cfg_t   active_r;     // Setting the divider really uses
  logic       xin_sel_r;    // Main clock taken from XIN
  logic [2:0] cnt_r;        // Source edges within one system cycle
  logic [2:0] cnt_nxt;      // Next count
  logic       sys_tick_r;   // System clock tick
  logic       instr_tick;   // Instruction tick from divider
  logic [7:0] mcyc_r;       // Machine cycle counter
  logic       xin_rise;     // XIN rising edge
  logic       ring_rise;    // On-chip oscillator rising edge
  logic       sub_rise;     // Sub oscillator rising edge
  logic       main_rise;    // Main clock edge after gating
  logic       src_rise;     // Edge of the chosen source
  logic       main_stop;    // Main clock halted
  logic       last_edge;    // Current edge closes a system cycle

  // ----------------------------------------------------------------
  // Oscillator inputs
  // ----------------------------------------------------------------
  scs_edge_sync u_sync_xin (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .osc_in     (main_xin_in),
    .rise_out   (xin_rise)
  );

  scs_edge_sync u_sync_ring (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .osc_in     (ring_osc_in),
    .rise_out   (ring_rise)
  );

  scs_edge_sync u_sync_sub (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .osc_in     (sub_xcin_in),
    .rise_out   (sub_rise)
  );

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Only the select register is writable; others ignore writes
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
      sel_r <= scs_cfg_t'(SCS_SEL_RST);
    else if (wr_in && addr_in == SCS_SEL_OFFS)
      sel_r <= scs_cfg_t'(wdata_in);
  end

  // ----------------------------------------------------------------
  // Main clock source choice
  // ----------------------------------------------------------------
  // Sticky: once a select instruction runs, XIN stays the main source
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
      xin_sel_r <= 1'b0;
    else if (ceramic_select_instr_in || rc_select_instr_in)
      xin_sel_r <= 1'b1;
  end

  // ----------------------------------------------------------------
  // Source gating
  // ----------------------------------------------------------------
  // Stop bit only bites while the sub clock drives the divider;
  // stopping the main clock under it would freeze the CPU
  assign main_stop = active_r.sub_sel && sel_r.main_stop;
  assign main_rise = main_stop ? 1'b0 : (xin_sel_r ? xin_rise : ring_rise);
  // Sub select wins whatever the stop bit holds
  assign src_rise  = active_r.sub_sel ? sub_rise : main_rise;

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  assign last_edge = src_rise && (cnt_r == scs_div_last(active_r.div));

  // Next count; wraps on the last source edge of a system cycle
  always_comb
  begin
    cnt_nxt = cnt_r;
    if (last_edge)
      cnt_nxt = 3'h0;
    else if (src_rise)
      cnt_nxt = cnt_r + 3'h1;
  end

  // Edge counter
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
      cnt_r <= 3'h0;
    else
      cnt_r <= cnt_nxt;
  end

  // System tick, registered
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
      sys_tick_r <= 1'b0;
    else
      sys_tick_r <= last_edge;
  end

  // ----------------------------------------------------------------
  // Applied setting
  // ----------------------------------------------------------------
  // A new ratio or source is taken only as a system cycle closes, so
  // no short system cycle appears; the cost is up to one slow cycle
  // of latency before a write takes effect
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
      active_r <= scs_cfg_t'(SCS_SEL_RST);
    else if (last_edge)
      active_r <= sel_r;
  end

  // ----------------------------------------------------------------
  // Instruction clock and machine cycles
  // ----------------------------------------------------------------
  scs_instr_div u_instr_div (
    .clk_sys_in     (clk_sys_in),
    .rst_n_in       (rst_n_in),
    .sys_tick_in    (sys_tick_r),
    .instr_tick_out (instr_tick)
  );

  // Every instruction tick is exactly one machine cycle
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
      mcyc_r <= 8'h00;
    else if (instr_tick)
      mcyc_r <= mcyc_r + 8'h01;
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Data stand one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
      rdata_out <= 4'h0;
    else if (rd_in)
    begin
      unique case (addr_in)
        SCS_SEL_OFFS  : rdata_out <= sel_r;
        SCS_STAT_OFFS : rdata_out <= {active_r.div, main_stop, xin_sel_r};
        SCS_MCYC_OFFS : rdata_out <= mcyc_r[3:0];
        default       : rdata_out <= 4'h0; // Unmapped address
      endcase
    end
    else
      rdata_out <= 4'h0;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // One driver for the whole struct keeps the port single-sourced
  assign ticks_out            = '{sys_tick: sys_tick_r, instr_tick: instr_tick};
  assign machine_cycle_out    = instr_tick;
  assign main_osc_enable_out  = ~main_stop;
  assign main_is_xin_out      = xin_sel_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_cycle_close;
    src_rise && cnt_r == scs_div_last(active_r.div);
  endsequence

  sequence s_tick_then_zero;
    sys_tick_r && cnt_r == 3'h0;
  endsequence

  property p_divide;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      s_cycle_close |=> s_tick_then_zero;
  endproperty

  a_divide_ratio : assert property (p_divide)
    else $error("system tick missing at terminal count");

  a_tick_cause : assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    sys_tick_r |-> $past(src_rise) && $past(cnt_r) == scs_div_last($past(active_r.div)))
    else $error("system tick without terminal count");

  a_sub_source : assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    active_r.sub_sel |-> src_rise == sub_rise)
    else $error("sub clock not feeding divider");

  a_main_source : assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    !active_r.sub_sel && !xin_sel_r |-> src_rise == ring_rise)
    else $error("main clock not feeding divider");

  a_reset_div8 : assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    $rose(rst_n_in) |-> active_r == scs_cfg_t'(SCS_SEL_RST) && !xin_sel_r)
    else $error("reset setting is not ring divided by eight");

  a_machine_cycle : assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    instr_tick |=> mcyc_r == $past(mcyc_r) + 8'h01)
    else $error("machine cycle count not one per instruction tick");

  a_ring_default : assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    $rose(xin_sel_r) |-> $past(ceramic_select_instr_in) || $past(rc_select_instr_in))
    else $error("main source left ring without instruction");

  a_main_stop : assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    active_r.sub_sel && sel_r.main_stop |-> !main_osc_enable_out && !main_rise)
    else $error("main clock runs while stopped");

  a_switch_edge : assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    $changed(active_r) |-> sys_tick_r)
    else $error("setting changed inside a system cycle");

  // ----------------------------------------------------------------
  // Divider count, hand-over of the setting, reset values and machine count
  // ----------------------------------------------------------------
  // A select write: one strobe at the select offset
  sequence s_sel_write;
    wr_in && addr_in == SCS_SEL_OFFS;
  endsequence

  // A source edge that does not close the system cycle
  sequence s_mid_edge;
    src_rise && !last_edge;
  endsequence

  a_write_lands : assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    s_sel_write |=> sel_r == scs_cfg_t'($past(wdata_in)))
    else $error("select write did not land");

  a_count_step : assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    s_mid_edge |=> cnt_r == $past(cnt_r) + 3'h1)
    else $error("divider count did not advance on a source edge");

  a_count_idle : assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    !src_rise |=> $stable(cnt_r))
    else $error("divider count moved without a source edge");

  // The ratio only changes as the count wraps, so the count never passes it
  a_count_range : assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    cnt_r <= scs_div_last(active_r.div))
    else $error("divider count beyond the applied ratio");

  a_apply_close : assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    last_edge |=> active_r == $past(sel_r))
    else $error("written setting not applied at cycle close");

  a_reset_select : assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    $rose(rst_n_in) |-> sel_r == scs_cfg_t'(SCS_SEL_RST) && !sys_tick_r && !instr_tick && rdata_out == 4'h0)
    else $error("select register or ticks not at reset values");

  a_mcyc_hold : assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    !instr_tick |=> $stable(mcyc_r))
    else $error("machine cycle count moved without an instruction tick");

  // ----------------------------------------------------------------
  // Main clock source choice
  // ----------------------------------------------------------------
  a_xin_source : assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    !active_r.sub_sel && xin_sel_r |-> src_rise == xin_rise)
    else $error("pin clock not feeding divider after select");

  a_stop_ignored : assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    !active_r.sub_sel |-> main_osc_enable_out)
    else $error("main clock stopped while it drives the divider");

  a_xin_sticky : assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    xin_sel_r |=> xin_sel_r)
    else $error("main source fell back to the on-chip oscillator");

endmodule : scs_clock_selector

// File: dv/system_clock_selector_test.sv
`timescale 1ns/100ps
// ------------------------------------------------------------------
// Bench for the system clock selector
// ------------------------------------------------------------------
module system_clock_selector_test;
  import scs_pkg::*;

  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic        clk_sys  = 1'b0;  // 100 MHz bench clock
  logic        rst_n    = 1'b0;  // Synchronous reset, active low
  logic        xin      = 1'b0;  // Main oscillator pin
  logic        ring     = 1'b0;  // On-chip oscillator
  logic        xcin     = 1'b0;  // Sub oscillator
  logic        cer_sel  = 1'b0;  // Ceramic select pulse
  logic        rc_sel   = 1'b0;  // RC select pulse
  logic [1:0]  addr     = 2'h0;  // Register address
  logic [3:0]  wdata    = 4'h0;  // Write data
  logic        wr       = 1'b0;  // Write strobe
  logic        rd       = 1'b0;  // Read strobe
  logic [3:0]  rdata;            // Read data
  scs_ticks_t  ticks;            // System and instruction ticks
  logic        mcyc;             // Machine cycle pulse
  logic        main_en;          // Main oscillator running
  logic        main_xin;         // Main source is the pin
  int          errors   = 0;     // Mismatch count
  int          checks   = 0;     // Comparison count
  int          n_sys    = 0;     // System ticks seen
  int          n_ins    = 0;     // Instruction ticks seen
  int          n_mc     = 0;     // Machine cycles since reset
  logic        xin_sel  = 1'b0;  // Bench copy of the select state
  logic [3:0]  d;                // Read result

  // Free-running clock
  initial
  begin
    forever #5 clk_sys = ~clk_sys;
  end

  scs_clock_selector dut (
    .clk_sys_in              (clk_sys),
    .rst_n_in                (rst_n),
    .main_xin_in             (xin),
    .ring_osc_in             (ring),
    .sub_xcin_in             (xcin),
    .ceramic_select_instr_in (cer_sel),
    .rc_select_instr_in      (rc_sel),
    .addr_in                 (addr),
    .wdata_in                (wdata),
    .wr_in                   (wr),
    .rd_in                   (rd),
    .rdata_out               (rdata),
    .ticks_out               (ticks),
    .machine_cycle_out       (mcyc),
    .main_osc_enable_out     (main_en),
    .main_is_xin_out         (main_xin)
  );

  // Tick counters; the machine count restarts with reset like the design's
  always @(posedge clk_sys)
  begin
    if (!rst_n)
      n_mc <= 0;
    else
    begin
      if (ticks.sys_tick === 1'b1)
        n_sys <= n_sys + 1;
      if (ticks.instr_tick === 1'b1)
        n_ins <= n_ins + 1;
      if (mcyc === 1'b1)
        n_mc <= n_mc + 1;
    end
  end

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic wr_reg(input logic [1:0] a, input logic [3:0] v);
    @(posedge clk_sys);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= v;
    @(posedge clk_sys);
    wr    <= 1'b0;
  endtask : wr_reg

  // Data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd_reg(input logic [1:0] a, output logic [3:0] v);
    @(posedge clk_sys);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd   <= 1'b0;
    #1 v = rdata;
  endtask : rd_reg

  // Pulse the oscillators in mask {sub, ring, pin} at 12.5 MHz, then let the pipeline drain
  task automatic osc(input logic [2:0] m, input int n);
    repeat (n)
    begin
      repeat (4) @(posedge clk_sys);
      {xcin, ring, xin} <= m;
      repeat (4) @(posedge clk_sys);
      {xcin, ring, xin} <= 3'b000;
    end
    repeat (10) @(posedge clk_sys);
  endtask : osc

  task automatic do_reset();
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    xin_sel = 1'b0;
  endtask : do_reset

  // Apply a setting, let every source close its cycle, then count 48 edges of the mask
  task automatic run_case(input logic [3:0] cfg, input logic [2:0] m, input int exp);
    int s0;
    int i0;
    int m0;
    wr_reg(SCS_SEL_OFFS, cfg);
    osc(3'b111, 16);
    rd_reg(SCS_STAT_OFFS, d);
    check("status", 32'(d), 32'({cfg[3:2], cfg[1] & cfg[0], xin_sel}));
    check("main enable", 32'(main_en), 32'(!(cfg[1] & cfg[0])));
    s0 = n_sys;
    i0 = n_ins;
    m0 = n_mc;
    osc(m, 48);
    check("sys ticks", 32'(n_sys - s0), 32'(exp));
    check("instr ticks", 32'(n_ins - i0), 32'(exp / 3));
    check("machine cycles", 32'(n_mc - m0), 32'(exp / 3));
  endtask : run_case

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results

  // ----------------------------------------------------------------
  // Watchdog: the sequence needs well under 20,000 cycles
  // ----------------------------------------------------------------
  initial
  begin
    #500_000;
    errors++;
    results();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    do_reset();
    rd_reg(SCS_SEL_OFFS, d);
    check("select reset", 32'(d), 32'(SCS_SEL_RST));
    check("main pin at reset", 32'(main_xin), 32'h0000_0000);
    // Untouched divider phase: ring edges over eight per system cycle
    run_case(4'hC, 3'b010, 6);
    run_case(4'hC, 3'b001, 0);
    // Stopped sources leave the applied setting behind the written one
    wr_reg(SCS_SEL_OFFS, 4'h1);
    rd_reg(SCS_SEL_OFFS, d);
    check("select written", 32'(d), 32'h0000_0001);
    rd_reg(SCS_STAT_OFFS, d);
    check("status lags", 32'(d), 32'h0000_000C);
    // Sub clock through every ratio, stop bit ignored for the source
    run_case(4'h1, 3'b100, 48);
    run_case(4'h7, 3'b100, 24);
    run_case(4'h9, 3'b100, 12);
    run_case(4'hF, 3'b100, 6);
    run_case(4'h9, 3'b011, 0);
    // Main clock from the on-chip oscillator
    run_case(4'h4, 3'b010, 24);
    run_case(4'h8, 3'b100, 0);
    run_case(4'h2, 3'b010, 48);
    // Unmapped offset reads zero and ignores writes
    wr_reg(2'h3, 4'hF);
    rd_reg(2'h3, d);
    check("unmapped", 32'(d), 32'h0000_0000);
    // All sources idle, so the cycle count is steady
    rd_reg(SCS_MCYC_OFFS, d);
    check("machine count", 32'(d), 32'(n_mc[3:0]));
    // RC select moves the main clock to the pin
    @(posedge clk_sys);
    rc_sel <= 1'b1;
    @(posedge clk_sys);
    rc_sel <= 1'b0;
    xin_sel = 1'b1;
    repeat (2) @(posedge clk_sys);
    check("rc select", 32'(main_xin), 32'h0000_0001);
    run_case(4'h0, 3'b001, 48);
    run_case(4'h0, 3'b010, 0);
    // Reset clears the choice; ceramic select sets it again
    do_reset();
    check("reset clears", 32'(main_xin), 32'h0000_0000);
    @(posedge clk_sys);
    cer_sel <= 1'b1;
    @(posedge clk_sys);
    cer_sel <= 1'b0;
    xin_sel = 1'b1;
    repeat (2) @(posedge clk_sys);
    check("ceramic select", 32'(main_xin), 32'h0000_0001);
    run_case(4'h4, 3'b001, 24);
    results();
  end

endmodule : system_clock_selector_test
